// ---- rtl/tdp_pkg.sv ----
// Constants for the two-wire digital potentiometer slave.
// Assumes a 100 MHz system clock that samples the serial pins.
package tdp_pkg;
   // Clock and the long non-volatile write time
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned T_NVWR_NS      = 5000000;              // 5 ms
   localparam int unsigned NVWR_CYCLES    = T_NVWR_NS / CLK_PERIOD_NS;
   localparam int unsigned NVWR_CNT_W     = 20;

   // Wiper and data slots
   localparam int unsigned WIPER_W        = 10;
   localparam int unsigned TAP_COUNT      = 1024;
   localparam int unsigned SLOT_COUNT     = 4;
   localparam logic [WIPER_W-1:0] SLOT_RST = 10'h200;             // Blank slot contents
   localparam logic [WIPER_W-1:0] WIPER_RST = 10'h000;

   // Identification byte layout
   localparam logic [3:0] DEV_TYPE_ID     = 4'ha;                 // Arbitrary value
   localparam int unsigned ID_LSB         = 4;
   localparam int unsigned ADDR_LSB       = 1;
   localparam int unsigned RW_POS         = 0;

   // Command byte layout
   localparam int unsigned OPC_LSB        = 5;
   localparam int unsigned ZERO_HI_POS    = 4;
   localparam int unsigned SEL_LSB        = 2;

   // Command opcodes
   localparam logic [2:0] OP_RD_WIPER     = 3'h4;
   localparam logic [2:0] OP_WR_WIPER     = 3'h5;
   localparam logic [2:0] OP_RD_SLOT      = 3'h6;
   localparam logic [2:0] OP_WR_SLOT      = 3'h7;
   localparam logic [2:0] OP_SLOT_TO_WIPER = 3'h3;
   localparam logic [2:0] OP_WIPER_TO_SLOT = 3'h2;

   typedef enum logic [1:0] {PEND_NONE, PEND_WIPER, PEND_SLOT} tdp_pend_e;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK, ST_WDAT, ST_WACK, ST_RDAT, ST_RACK, ST_WAIT
   } tdp_state_e;
endpackage

// ---- rtl/tdp_top.sv ----
// Two-wire serial slave holding a 10-bit wiper position and four stored slots.
// Assumes scl/sda/wp/address pins are asynchronous to clk_sys and slow
// against it; the serial clock always comes from the bus master.
`timescale 1ns/1ps
module tdp_top #(
   parameter int unsigned NVWR_CYCLES = tdp_pkg::NVWR_CYCLES
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   input  wire logic          scl_i,
   input  wire logic          sda_i,
   output      logic          sda_o,
   output      logic          sda_oe,
   input  wire logic [2:0]    addr_select_pins,
   input  wire logic          wp_b,
   output      logic [9:0]    wiper_position_reg,
   output      logic [1023:0] tap_select,
   output      logic          nv_busy
);
   localparam logic [tdp_pkg::NVWR_CNT_W-1:0] NVWR_LOAD =
      tdp_pkg::NVWR_CNT_W'(NVWR_CYCLES - 1);

   // Pin synchronisers; only the second stage and later are read
   logic [5:0] sync_a_ff;
   logic [5:0] sync_b_ff;
   logic       scl_d_ff;
   logic       sda_d_ff;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync_a_ff <= 6'h3f;
         sync_b_ff <= 6'h3f;
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
      end else begin
         sync_a_ff <= {scl_i, sda_i, wp_b, addr_select_pins};
         sync_b_ff <= sync_a_ff;
         scl_d_ff  <= sync_b_ff[5];
         sda_d_ff  <= sync_b_ff[4];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic       wp_s;
   logic [2:0] addr_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   assign scl_s    = sync_b_ff[5];
   assign sda_s    = sync_b_ff[4];
   assign wp_s     = sync_b_ff[3];
   assign addr_s   = sync_b_ff[2:0];
   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   // Data edges while the clock stays high mark frame boundaries
   assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   tdp_pkg::tdp_state_e st_ff, nxt_st;
   logic [2:0]            bit_ff, nxt_bit;
   logic [7:0]            rx_ff, nxt_rx;
   logic [7:0]            tx_ff, nxt_tx;
   logic                  ack_rise_ff, nxt_ack_rise;
   logic                  ack_ok_ff, nxt_ack_ok;
   logic                  rw_ff, nxt_rw;
   logic [2:0]            op_ff, nxt_op;
   logic [1:0]            sel_ff, nxt_sel;
   logic                  byte_ff, nxt_byte;
   logic [7:0]            dlo_ff, nxt_dlo;
   tdp_pkg::tdp_pend_e    pend_ff, nxt_pend;
   logic [9:0]            pval_ff, nxt_pval;
   logic                  oe_ff, nxt_oe;
   logic [9:0]            wiper_ff, nxt_wiper;
   logic [9:0]            slot_ff [tdp_pkg::SLOT_COUNT];
   logic [9:0]            nxt_slot [tdp_pkg::SLOT_COUNT];
   logic                  busy_ff, nxt_busy;
   logic [tdp_pkg::NVWR_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic                  loaded_ff, nxt_loaded;

   logic [7:0] byte_in;
   logic [9:0] rd_val;
   logic       op_legal;
   logic       nv_we;
   assign byte_in = {rx_ff[6:0], sda_s};
   assign rd_val  = (op_ff == tdp_pkg::OP_RD_WIPER) ? wiper_ff : slot_ff[sel_ff];
   // Reads are legal only with the read bit set, writes and transfers only without it
   assign op_legal = rw_ff ?
      (byte_in[7:5] == tdp_pkg::OP_RD_WIPER || byte_in[7:5] == tdp_pkg::OP_RD_SLOT) :
      (byte_in[7:5] == tdp_pkg::OP_WR_WIPER || byte_in[7:5] == tdp_pkg::OP_WR_SLOT ||
       byte_in[7:5] == tdp_pkg::OP_SLOT_TO_WIPER ||
       byte_in[7:5] == tdp_pkg::OP_WIPER_TO_SLOT);

   // Serial protocol: bit counting, acknowledge and shifting out
   always_comb begin
      nxt_st = st_ff; nxt_bit = bit_ff; nxt_rx = rx_ff; nxt_tx = tx_ff;
      nxt_ack_rise = ack_rise_ff; nxt_ack_ok = ack_ok_ff; nxt_rw = rw_ff;
      nxt_op = op_ff; nxt_sel = sel_ff; nxt_byte = byte_ff; nxt_dlo = dlo_ff;
      nxt_pend = pend_ff; nxt_pval = pval_ff; nxt_oe = oe_ff;
      if (stop_det) begin
         nxt_st   = tdp_pkg::ST_IDLE;
         nxt_oe   = 1'b0;
         nxt_pend = tdp_pkg::PEND_NONE;
      end else if (start_det) begin
         nxt_st   = tdp_pkg::ST_ADDR;
         nxt_bit  = 3'h0;
         nxt_oe   = 1'b0;
         nxt_pend = tdp_pkg::PEND_NONE;
      end else begin
         case (st_ff)
            tdp_pkg::ST_ADDR, tdp_pkg::ST_CMD, tdp_pkg::ST_WDAT: begin
               if (scl_rise) begin
                  nxt_rx  = byte_in;
                  nxt_bit = bit_ff + 3'h1;
                  nxt_ack_rise = 1'b0;
                  if (bit_ff == 3'h7) begin
                     if (st_ff == tdp_pkg::ST_ADDR) begin
                        // Busy or foreign address: stay silent until the next start
                        if (byte_in[7:4] == tdp_pkg::DEV_TYPE_ID &&
                            byte_in[3:1] == addr_s && !busy_ff) begin
                           nxt_st = tdp_pkg::ST_AACK;
                           nxt_rw = byte_in[tdp_pkg::RW_POS];
                        end else begin
                           nxt_st = tdp_pkg::ST_IDLE;
                        end
                     end else if (st_ff == tdp_pkg::ST_CMD) begin
                        nxt_op  = byte_in[7:5];
                        nxt_sel = byte_in[3:2];
                        nxt_st  = (op_legal && !byte_in[tdp_pkg::ZERO_HI_POS] &&
                                   byte_in[1:0] == 2'h0) ? tdp_pkg::ST_CACK : tdp_pkg::ST_IDLE;
                     end else begin
                        nxt_st = tdp_pkg::ST_WACK;
                        if (!byte_ff) begin
                           nxt_dlo = byte_in;
                        end else begin
                           nxt_pval = {byte_in[1:0], dlo_ff};
                           nxt_pend = (op_ff == tdp_pkg::OP_WR_SLOT) ?
                                      tdp_pkg::PEND_SLOT : tdp_pkg::PEND_WIPER;
                        end
                     end
                  end
               end
            end
            tdp_pkg::ST_AACK, tdp_pkg::ST_CACK, tdp_pkg::ST_WACK: begin
               if (scl_rise) begin
                  nxt_ack_rise = 1'b1;
               end else if (scl_fall && !ack_rise_ff) begin
                  nxt_oe = 1'b1;
               end else if (scl_fall) begin
                  nxt_oe  = 1'b0;
                  nxt_bit = 3'h0;
                  if (st_ff == tdp_pkg::ST_AACK) begin
                     nxt_st = tdp_pkg::ST_CMD;
                  end else if (st_ff == tdp_pkg::ST_WACK) begin
                     nxt_byte = 1'b1;
                     nxt_st   = byte_ff ? tdp_pkg::ST_WAIT : tdp_pkg::ST_WDAT;
                  end else if (rw_ff) begin
                     nxt_tx   = rd_val[7:0];
                     nxt_byte = 1'b0;
                     nxt_oe   = ~rd_val[7];
                     nxt_st   = tdp_pkg::ST_RDAT;
                  end else if (op_ff == tdp_pkg::OP_SLOT_TO_WIPER) begin
                     nxt_pval = slot_ff[sel_ff];
                     nxt_pend = tdp_pkg::PEND_WIPER;
                     nxt_st   = tdp_pkg::ST_WAIT;
                  end else if (op_ff == tdp_pkg::OP_WIPER_TO_SLOT) begin
                     nxt_pval = wiper_ff;
                     nxt_pend = tdp_pkg::PEND_SLOT;
                     nxt_st   = tdp_pkg::ST_WAIT;
                  end else begin
                     nxt_byte = 1'b0;
                     nxt_st   = tdp_pkg::ST_WDAT;
                  end
               end
            end
            tdp_pkg::ST_RDAT: begin
               if (scl_rise) begin
                  nxt_bit = bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     nxt_st = tdp_pkg::ST_RACK;
                     nxt_ack_rise = 1'b0;
                  end
               end else if (scl_fall) begin
                  nxt_tx = {tx_ff[6:0], 1'b0};
                  nxt_oe = ~tx_ff[6];
               end
            end
            tdp_pkg::ST_RACK: begin
               if (scl_rise) begin
                  nxt_ack_rise = 1'b1;
                  nxt_ack_ok   = ~sda_s;
               end else if (scl_fall && !ack_rise_ff) begin
                  nxt_oe = 1'b0;
               end else if (scl_fall) begin
                  // Master acknowledged the low byte: send the two high bits next
                  if (ack_ok_ff && !byte_ff) begin
                     nxt_tx   = {6'h00, rd_val[9:8]};
                     nxt_oe   = 1'b1;
                     nxt_byte = 1'b1;
                     nxt_bit  = 3'h0;
                     nxt_st   = tdp_pkg::ST_RDAT;
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_st = tdp_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= tdp_pkg::ST_IDLE; bit_ff <= 3'h0; rx_ff <= 8'h00; tx_ff <= 8'h00;
         ack_rise_ff <= 1'b0; ack_ok_ff <= 1'b0; rw_ff <= 1'b0; op_ff <= 3'h0;
         sel_ff <= 2'h0; byte_ff <= 1'b0; dlo_ff <= 8'h00;
         pend_ff <= tdp_pkg::PEND_NONE; pval_ff <= 10'h000; oe_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st; bit_ff <= nxt_bit; rx_ff <= nxt_rx; tx_ff <= nxt_tx;
         ack_rise_ff <= nxt_ack_rise; ack_ok_ff <= nxt_ack_ok; rw_ff <= nxt_rw;
         op_ff <= nxt_op; sel_ff <= nxt_sel; byte_ff <= nxt_byte; dlo_ff <= nxt_dlo;
         pend_ff <= nxt_pend; pval_ff <= nxt_pval; oe_ff <= nxt_oe;
      end
   end

   // Stored write commits only with write protect released and no write running
   assign nv_we = stop_det && pend_ff == tdp_pkg::PEND_SLOT && wp_s && !busy_ff;

   // Storage: wiper, slots, recall after reset and the write timer
   always_comb begin
      nxt_wiper  = wiper_ff;
      nxt_busy   = busy_ff;
      nxt_cnt    = cnt_ff;
      nxt_loaded = 1'b1;
      for (int i = 0; i < tdp_pkg::SLOT_COUNT; i++) begin
         nxt_slot[i] = slot_ff[i];
      end
      if (!loaded_ff) begin
         nxt_wiper = slot_ff[0];
      end else if (stop_det && pend_ff == tdp_pkg::PEND_WIPER) begin
         nxt_wiper = pval_ff;
      end
      if (nv_we) begin
         nxt_slot[sel_ff] = pval_ff;
         nxt_busy = 1'b1;
         nxt_cnt  = NVWR_LOAD;
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wiper_ff  <= tdp_pkg::WIPER_RST;
         busy_ff   <= 1'b0;
         cnt_ff    <= '0;
         loaded_ff <= 1'b0;
         for (int i = 0; i < tdp_pkg::SLOT_COUNT; i++) begin
            slot_ff[i] <= tdp_pkg::SLOT_RST;
         end
      end else begin
         wiper_ff  <= nxt_wiper;
         busy_ff   <= nxt_busy;
         cnt_ff    <= nxt_cnt;
         loaded_ff <= nxt_loaded;
         slot_ff   <= nxt_slot;
      end
   end

   // One-hot tap decode, one switch per code
   for (genvar i = 0; i < tdp_pkg::TAP_COUNT; i++) begin : g_tap
      assign tap_select[i] = (wiper_ff == 10'(i));
   end

   assign sda_o              = 1'b0;
   assign sda_oe             = oe_ff;
   assign wiper_position_reg = wiper_ff;
   assign nv_busy            = busy_ff;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_drive_after_fall: assert property ($changed(oe_ff) |-> $past(scl_fall || start_det || stop_det)) else $error("Data line changed outside a clock fall");
   chk_never_high: assert property (sda_o == 1'b0) else $error("Data line driven high");
   chk_tap_onehot: assert property ($onehot(tap_select)) else $error("Tap select not one-hot");
   chk_power_recall: assert property ($rose(loaded_ff) |-> wiper_ff == $past(slot_ff[0])) else $error("Wiper not recalled from slot zero");
   chk_stop_abandon: assert property (stop_det |=> st_ff == tdp_pkg::ST_IDLE && !oe_ff) else $error("Stop did not abandon command");
   chk_wp_refuse: assert property (stop_det && pend_ff == tdp_pkg::PEND_SLOT && !wp_s |=> $stable(slot_ff[sel_ff]) && !$rose(busy_ff)) else $error("Protected slot written");
   chk_wp_wiper_hold: assert property (stop_det && pend_ff == tdp_pkg::PEND_SLOT && !wp_s |=> $stable(wiper_ff)) else $error("Refused write moved wiper");
   chk_busy_noack: assert property (st_ff == tdp_pkg::ST_ADDR && scl_rise && bit_ff == 3'h7 && busy_ff |=> st_ff == tdp_pkg::ST_IDLE) else $error("Address taken while busy");
   chk_addr_mismatch: assert property (st_ff == tdp_pkg::ST_ADDR && scl_rise && bit_ff == 3'h7 && byte_in[3:1] != addr_s |=> st_ff == tdp_pkg::ST_IDLE) else $error("Foreign address accepted");
   chk_busy_start: assert property (nv_we |=> busy_ff && cnt_ff == NVWR_LOAD) else $error("Write timer not started");
   chk_rx_on_rise: assert property ($changed(rx_ff) |-> $past(scl_rise)) else $error("Bit captured off the rising edge");
   chk_wiper_write: assert property (stop_det && pend_ff == tdp_pkg::PEND_WIPER && loaded_ff |=> wiper_ff == $past(pval_ff)) else $error("Wiper write lost");

   cov_wiper_write: cover property (stop_det && pend_ff == tdp_pkg::PEND_WIPER);
   cov_read_done: cover property (st_ff == tdp_pkg::ST_RACK && byte_ff ##1 st_ff == tdp_pkg::ST_IDLE);
   cov_nv_write: cover property (nv_we);
   cov_busy_poll: cover property (busy_ff && st_ff == tdp_pkg::ST_ADDR && scl_rise && bit_ff == 3'h7);
endmodule

// ---- sim/tdp_master.sv ----
// Bus master model for the two-wire potentiometer slave: makes the clock
// and frames. Assumes the bench resolves the open-drain data wire (pull-up).
`timescale 1ns/1ps
module tdp_master (
   input  wire logic clk_sys,
   input  wire logic sda_w,
   output      logic scl,
   output      logic sda_pull
);
   // Idle bus: clock stands high and data is released between frames
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One clock pulse, 8-cycle phases so the slave's synchronisers keep up
   task automatic bit_x(input logic v, output logic r);
      wt(4);
      sda_pull <= ~v; // Data moves only while the clock is low
      wt(4);
      scl <= 1'b1;
      wt(4);
      r = sda_w;
      wt(4);
      scl <= 1'b0;
   endtask

   task automatic start();
      wt(4);
      sda_pull <= 1'b0;
      wt(4);
      scl <= 1'b1;
      wt(8);
      sda_pull <= 1'b1;
      wt(8);
      scl <= 1'b0;
   endtask

   // Leaves the clock high: it stands still until the next frame
   task automatic stop();
      wt(4);
      sda_pull <= 1'b1;
      wt(4);
      scl <= 1'b1;
      wt(8);
      sda_pull <= 1'b0;
      wt(8);
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = (r === 1'b0);
   endtask

   task automatic rd_byte(output logic [7:0] b, input logic mack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(~mack, r);
   endtask
endmodule

// ---- sim/tdp_top_test.sv ----
// Self-checking bench for the two-wire potentiometer slave.
// Assumes tdp_master drives the bus and a pull-up holds the idle data wire.
`timescale 1ns/1ps
module tdp_top_test;
   localparam int unsigned NVW = 2000; // Short stored write keeps the run brief
   logic          clk_sys = 1'b0;
   logic          rst_b   = 1'b0;
   logic [2:0]    pins    = 3'h2;
   logic          wp_b    = 1'b1;
   logic          sda_o;
   logic          sda_oe;
   logic          nv_busy;
   logic [9:0]    wiper;
   logic [1023:0] taps;
   logic          m_scl;
   logic          m_pull;
   logic          sda_w;
   logic          scl_q   = 1'b0;
   logic          oe_q    = 1'b0;
   int            num_errors = 0;
   int            n_checks   = 0;
   int            bad_edge   = 0;
   int            bad_high   = 0;
   logic [9:0]    slot_v [4] = '{10'h3ff, 10'h000, 10'h2c3, 10'h15a};

   always #5 clk_sys = ~clk_sys;

   // Wired-AND of both open-drain drivers with a pull-up
   assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_pull;

   tdp_top #(.NVWR_CYCLES(NVW)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .scl_i(m_scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pins(pins), .wp_b(wp_b),
      .wiper_position_reg(wiper), .tap_select(taps), .nv_busy(nv_busy));

   tdp_master m (.clk_sys(clk_sys), .sda_w(sda_w), .scl(m_scl), .sda_pull(m_pull));

   // Sticky watch: device output may move only while the clock is low
   always @(posedge clk_sys) begin
      scl_q <= m_scl;
      oe_q  <= sda_oe;
      if (rst_b && m_scl && scl_q && sda_oe !== oe_q) bad_edge <= bad_edge + 1;
      if (sda_oe === 1'b1 && sda_o !== 1'b0) bad_high <= bad_high + 1;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] cb(input logic [2:0] op, input logic [1:0] sel);
      return {op, 1'b0, sel, 2'b00};
   endfunction

   function automatic logic [7:0] ab(input logic [2:0] a, input logic rd_n);
      return {tdp_pkg::DEV_TYPE_ID, a, rd_n};
   endfunction

   // Full write frame; nd data bytes, low byte first; k counts acks
   task automatic wr(input logic [2:0] a, input logic [7:0] c, input logic [9:0] v,
                     input int nd, output int k);
      logic ack;
      m.start();
      m.wr_byte(ab(a, 1'b0), ack);
      k = ack;
      m.wr_byte(c, ack);
      k += ack;
      for (int i = 0; i < nd; i++) begin
         m.wr_byte((i == 0) ? v[7:0] : {6'h00, v[9:8]}, ack);
         k += ack;
      end
      m.stop();
   endtask

   task automatic rd(input logic [1:0] sel, input logic [2:0] op, output logic [9:0] v,
                     output int k);
      logic       ack;
      logic [7:0] lo;
      logic [7:0] hi;
      m.start();
      m.wr_byte(ab(pins, 1'b1), ack);
      k = ack;
      m.wr_byte(cb(op, sel), ack);
      k += ack;
      m.rd_byte(lo, 1'b1);
      m.rd_byte(hi, 1'b0);
      m.stop();
      v = {hi[1:0], lo};
   endtask

   task automatic wait_idle();
      int i;
      for (i = 0; i < 4 * NVW && nv_busy !== 1'b0; i++) @(posedge clk_sys);
      if (i == 4 * NVW) begin
         check(nv_busy, 1'b0, "busy timeout");
         stop_test();
      end
   endtask

   task automatic t_basic();
      logic       ack;
      logic [9:0] v;
      int         k;
      check(wiper, tdp_pkg::SLOT_RST, "wiper at reset");
      check(taps === (1024'h1 << tdp_pkg::SLOT_RST), 1'b1, "taps at reset");
      check(sda_oe, 1'b0, "sda_oe at reset");
      m.wr_byte(ab(pins, 1'b0), ack);
      m.stop();
      check(ack, 1'b0, "ack without start");
      wr(pins, cb(tdp_pkg::OP_WR_WIPER, 2'h0), 10'h155, 2, k);
      check(k, 4, "wiper write acks");
      check(wiper, 10'h155, "wiper written");
      check(taps === (1024'h1 << 10'h155), 1'b1, "one tap");
      rd(2'h0, tdp_pkg::OP_RD_WIPER, v, k);
      check(k, 2, "read acks");
      check(v, 10'h155, "wiper read");
      wr(3'h3, cb(tdp_pkg::OP_WR_WIPER, 2'h0), 10'h2aa, 2, k);
      check(k, 0, "foreign address acks");
      check(wiper, 10'h155, "wiper kept");
      pins <= 3'h5;
      m.wt(4);
      wr(3'h5, cb(tdp_pkg::OP_WR_WIPER, 2'h0), 10'h2aa, 2, k);
      check(k, 4, "new pins acks");
      check(wiper, 10'h2aa, "wiper via new pins");
      pins <= 3'h2;
      m.wt(4);
      $display("test basic done");
   endtask

   task automatic t_slots();
      logic       ack;
      logic [9:0] v;
      int         k;
      for (int s = 0; s < 4; s++) begin
         wr(pins, cb(tdp_pkg::OP_WR_SLOT, 2'(s)), slot_v[s], 2, k);
         check(k, 4, "slot write acks");
         check(nv_busy, 1'b1, "busy after stop");
         m.start();
         m.wr_byte(ab(pins, 1'b0), ack);
         m.stop();
         check(ack, 1'b0, "poll while busy");
         wait_idle();
      end
      for (int s = 0; s < 4; s++) begin
         rd(2'(s), tdp_pkg::OP_RD_SLOT, v, k);
         check(v, slot_v[s], "slot read back");
      end
      wr(pins, cb(tdp_pkg::OP_SLOT_TO_WIPER, 2'h2), 10'h000, 0, k);
      check(k, 2, "transfer acks");
      check(wiper, slot_v[2], "slot to wiper");
      wr(pins, cb(tdp_pkg::OP_WIPER_TO_SLOT, 2'h1), 10'h000, 0, k);
      wait_idle();
      rd(2'h1, tdp_pkg::OP_RD_SLOT, v, k);
      check(v, slot_v[2], "wiper to slot");
      $display("test slots done");
   endtask

   task automatic t_guard();
      logic       r;
      logic       ack;
      logic [9:0] v;
      int         k;
      wp_b <= 1'b0;
      m.wt(4);
      wr(pins, cb(tdp_pkg::OP_WR_SLOT, 2'h3), 10'h011, 2, k);
      check(k, 4, "protected write acks");
      check(nv_busy, 1'b0, "no busy when protected");
      check(wiper, slot_v[2], "wiper after refusal");
      wp_b <= 1'b1;
      m.wt(4);
      rd(2'h3, tdp_pkg::OP_RD_SLOT, v, k);
      check(v, slot_v[3], "protected slot kept");
      m.start();
      m.wr_byte(ab(pins, 1'b0), ack);
      m.wr_byte(cb(tdp_pkg::OP_WR_WIPER, 2'h0), ack);
      m.bit_x(1'b0, r);
      m.bit_x(1'b1, r);
      m.bit_x(1'b0, r);
      m.stop();
      check(sda_oe, 1'b0, "line after abort");
      check(wiper, slot_v[2], "wiper after abort");
      wr(pins, cb(tdp_pkg::OP_WR_WIPER, 2'h0), 10'h001, 2, k);
      check(k, 4, "acks after abort");
      check(wiper, 10'h001, "wiper after abort");
      check(bad_edge, 0, "moves while clock high");
      check(bad_high, 0, "data driven high");
      $display("test guard done");
   endtask

   // Reset held 20 cycles, then synchronisers are given time to settle
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      m.wt(6);
      t_basic();
      t_slots();
      t_guard();
      stop_test();
   end
endmodule
